// >>> common/srg_pkg.sv
// Purpose: constants and types for the sram region decode and gating block
// Assumes: one 100 MHz clock, ahb5 data side, plain config write strobe
// Notes:   bases are full byte addresses; decode keys are slices of them
package srg_pkg;

  // ****************************************************************
  // widths of the protection units and the data path
  // ****************************************************************
  localparam int unsigned SRG_DATA_W      = 32;
  localparam int unsigned SRG_UNIT_ADDR_W = 22;
  localparam int unsigned SRG_MASTER_W    = 5;
  localparam int unsigned SRG_USER_W      = 0;  // sideband disabled
  localparam int unsigned SRG_BLOCK_SIZE_LOG2 = 8;
  localparam int unsigned SRG_NUM_UNITS   = 3;
  localparam int unsigned SRG_NUM_MON     = 2;
  localparam int unsigned SRG_LUT_AW      = SRG_UNIT_ADDR_W - SRG_BLOCK_SIZE_LOG2 - 5;
  localparam int unsigned SRG_LUT_WORDS   = 1 << SRG_LUT_AW;
  localparam int unsigned SRG_RAM_ADDR_W  = 24;
  localparam int unsigned SRG_RDATA_W     = 4 * SRG_DATA_W;

  // ****************************************************************
  // locked-access response: 0 adds wait states, 1 drives an error
  // ****************************************************************
  localparam logic locked_access_response_select = 1'b0;

  // ****************************************************************
  // address map
  // ****************************************************************
  localparam logic [31:0] SRG_CODE_NS_BASE  = 32'h0000_0000;
  localparam logic [31:0] SRG_CODE_S_BASE   = 32'h1000_0000;
  localparam logic [31:0] SRG_EXPA_NS_BASE  = 32'h2800_0000;
  localparam logic [31:0] SRG_EXPB_NS_BASE  = 32'h2820_0000;
  localparam logic [31:0] SRG_EXPA_S_BASE   = 32'h3800_0000;
  localparam logic [31:0] SRG_EXPB_S_BASE   = 32'h3820_0000;
  localparam logic [31:0] SRG_LARGE_BASE    = 32'h8000_0000;

  // config frames of the three protection units, index = irq bit
  localparam logic [2:0][31:0] SRG_CFG_BASE = {32'h5800_9000, 32'h5800_8000,
                                               32'h5800_7000};
  localparam logic [11:0] SRG_CFG_IRQ_CLR_OFF = 12'h800;
  localparam logic [11:0] SRG_CFG_LOCK_OFF    = 12'h804;

  // ****************************************************************
  // reset values and ahb codes
  // ****************************************************************
  localparam logic [31:0] SRG_RDATA_RST = 32'h0000_0000;
  localparam logic [2:0]  SRG_HSIZE_BYTE = 3'h0;
  localparam logic [2:0]  SRG_HSIZE_HALF = 3'h1;

  typedef enum logic [2:0] {
    SRG_BANK_CODE  = 3'b000,
    SRG_BANK_EXPA  = 3'b001,
    SRG_BANK_EXPB  = 3'b010,
    SRG_BANK_LARGE = 3'b011,
    SRG_BANK_NONE  = 3'b100
  } srg_bank_t;

  typedef enum logic [2:0] {
    SRG_ST_IDLE  = 3'b000,
    SRG_ST_CHECK = 3'b001,
    SRG_ST_READ  = 3'b010,
    SRG_ST_RDATA = 3'b011,
    SRG_ST_ERR   = 3'b100
  } srg_state_t;

endpackage

// >>> design/srg_gate.sv
// Purpose: decode and security gating in front of four synchronous sram banks
// Assumes: ahb5 masters on CLOCK_IN, config writes as one-cycle strobes
// Notes:   every access takes at least one wait state; outputs are flops
//
// Notes on behaviour
// - code ram at non-secure and secure bases
// - upper 4MB of code window aliases lower
// - alias halves share one security attribute
// - unmapped code addresses get bus error
// - code unit config at base, irq bit 0
// - units use 32-bit data, 22-bit address
// - units take 5-bit master identifier
// - user sideband width zero, ports absent
// - attributes per 256-byte block
// - locked unit stalls access until released
// - two 2MB expansion banks, secure alias
// - addresses after expansion banks get error
// - expansion banks have monitor and unit
// - bank a unit config base, irq bit 1
// - bank b unit config base, irq bit 2
// - 16MB non-secure ram, rest errors
`timescale 1ns/1ns

module srg_gate
  import srg_pkg::*;
(
  input  wire logic                      CLOCK_IN,
  input  wire logic                      RESETN_IN,
  input  wire logic                      HSEL_IN,
  input  wire logic [31:0]               HADDR_IN,
  input  wire logic [1:0]                HTRANS_IN,
  input  wire logic                      HWRITE_IN,
  input  wire logic [2:0]                HSIZE_IN,
  input  wire logic                      HREADY_IN,
  input  wire logic [SRG_DATA_W-1:0]     HWDATA_IN,
  input  wire logic                      HNONSEC_IN,
  input  wire logic                      HEXCL_IN,
  input  wire logic [SRG_MASTER_W-1:0]   HMASTER_IN,
  output logic      [SRG_DATA_W-1:0]     HRDATA_OUT,
  output logic                           HREADYOUT_OUT,
  output logic                           HRESP_OUT,
  output logic                           HEXOKAY_OUT,
  input  wire logic                      CFG_WRITE_IN,
  input  wire logic [31:0]               CFG_ADDR_IN,
  input  wire logic [31:0]               CFG_WDATA_IN,
  output logic      [3:0]                RAM_SEL_OUT,
  output logic      [SRG_RAM_ADDR_W-1:0] RAM_ADDR_OUT,
  output logic                           RAM_RD_OUT,
  output logic                           RAM_WE_OUT,
  output logic      [3:0]                RAM_BE_OUT,
  output logic      [SRG_DATA_W-1:0]     RAM_WDATA_OUT,
  input  wire logic [SRG_RDATA_W-1:0]    RAM_RDATA_IN,
  output logic      [2:0]                SEC_EXP_PROT_IRQ_OUT,
  output logic      [2:0]                UNIT_LOCKED_OUT
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  srg_state_t                   state_q;
  logic [31:0]                  addr_q;
  logic                         write_q;
  logic [2:0]                   size_q;
  logic                         nonsec_q;
  logic                         excl_q;
  logic [SRG_MASTER_W-1:0]      master_q;
  srg_bank_t                    bank;
  logic [SRG_UNIT_ADDR_W-1:0]   unit_off;
  logic [SRG_RAM_ADDR_W-1:0]    ram_addr;
  logic [3:0]                   byte_en;
  logic [1:0]                   unit_idx;
  logic                         has_unit;
  logic                         has_mon;
  logic [SRG_NUM_UNITS-1:0]     unit_attr;
  logic [SRG_NUM_UNITS-1:0]     unit_lock_q;
  logic [SRG_NUM_UNITS-1:0]     irq_q;
  logic [SRG_NUM_MON-1:0]       mon_pass;
  logic                         take;
  logic                         dec_err;
  logic                         lock_hit;
  logic                         denied;
  logic                         access_ok;
  logic                         excl_pass;
  logic                         do_write;

  // ****************************************************************
  // address decode of the captured request
  // ****************************************************************
  always_comb begin
    bank     = SRG_BANK_NONE;
    unit_off = '0;
    if (addr_q[31:23] == SRG_CODE_NS_BASE[31:23] ||
        addr_q[31:23] == SRG_CODE_S_BASE[31:23]) begin
      bank     = SRG_BANK_CODE;
      unit_off = addr_q[SRG_UNIT_ADDR_W-1:0];
    end else if (addr_q[31:21] == SRG_EXPA_NS_BASE[31:21] ||
                 addr_q[31:21] == SRG_EXPA_S_BASE[31:21]) begin
      bank     = SRG_BANK_EXPA;
      unit_off = {1'b0, addr_q[20:0]};
    end else if (addr_q[31:21] == SRG_EXPB_NS_BASE[31:21] ||
                 addr_q[31:21] == SRG_EXPB_S_BASE[31:21]) begin
      bank     = SRG_BANK_EXPB;
      unit_off = {1'b0, addr_q[20:0]};
    end else if (addr_q[31:24] == SRG_LARGE_BASE[31:24]) begin
      bank     = SRG_BANK_LARGE;
    end
  end
  // anything else selected is unmapped and answered with an error
  assign dec_err  = (bank == SRG_BANK_NONE);
  assign ram_addr = (bank == SRG_BANK_LARGE) ? addr_q[SRG_RAM_ADDR_W-1:0]
                                             : {2'b00, unit_off};
  assign unit_idx = bank[1:0];
  assign has_unit = (bank == SRG_BANK_CODE) || (bank == SRG_BANK_EXPA) ||
                    (bank == SRG_BANK_EXPB);
  assign has_mon  = (bank == SRG_BANK_EXPA) || (bank == SRG_BANK_EXPB);
  // byte lanes from transfer size and low address bits
  always_comb begin
    if (size_q == SRG_HSIZE_BYTE) begin
      byte_en = 4'h1 << addr_q[1:0];
    end else if (size_q == SRG_HSIZE_HALF) begin
      byte_en = addr_q[1] ? 4'hC : 4'h3;
    end else begin
      byte_en = 4'hF;
    end
  end

  // ****************************************************************
  // protection units: block attribute tables, lock and irq per unit
  // ****************************************************************
  genvar u;
  generate
    for (u = 0; u < SRG_NUM_UNITS; u++) begin : g_unit
      logic [31:0]              lut_mem [SRG_LUT_WORDS];
      logic [SRG_LUT_WORDS-1:0] lut_valid_q;
      logic                     cfg_hit;
      logic                     irq_set;
      logic [SRG_LUT_AW-1:0]    rd_word;
      logic [4:0]               rd_bit;
      assign cfg_hit = CFG_WRITE_IN &&
                       (CFG_ADDR_IN[31:12] == SRG_CFG_BASE[u][31:12]);
      assign rd_word = unit_off[SRG_UNIT_ADDR_W-1 -: SRG_LUT_AW];
      assign rd_bit  = unit_off[SRG_BLOCK_SIZE_LOG2 +: 5];
      // one attribute bit per block, 1 means non-secure; unwritten reads secure
      always_ff @(posedge CLOCK_IN) begin
        if (cfg_hit && !CFG_ADDR_IN[11]) begin
          lut_mem[CFG_ADDR_IN[SRG_LUT_AW+1:2]] <= CFG_WDATA_IN;
        end
      end
      always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
          lut_valid_q <= '0;
        end else if (cfg_hit && !CFG_ADDR_IN[11]) begin
          lut_valid_q[CFG_ADDR_IN[SRG_LUT_AW+1:2]] <= 1'b1;
        end
      end
      assign unit_attr[u] = lut_valid_q[rd_word] && lut_mem[rd_word][rd_bit];
      // programming lock
      always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
          unit_lock_q[u] <= 1'b0;
        end else if (cfg_hit && CFG_ADDR_IN[11:0] == SRG_CFG_LOCK_OFF) begin
          unit_lock_q[u] <= CFG_WDATA_IN[0];
        end
      end
      // sticky irq on a denied access; a new denial beats the clear
      assign irq_set = denied && (unit_idx == 2'(u));
      always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
          irq_q[u] <= 1'b0;
        end else if (irq_set) begin
          irq_q[u] <= 1'b1;
        end else if (cfg_hit && CFG_ADDR_IN[11:0] == SRG_CFG_IRQ_CLR_OFF &&
                     CFG_WDATA_IN[0]) begin
          irq_q[u] <= 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // gating decisions for the request held in the check state
  // ****************************************************************
  assign lock_hit  = has_unit && unit_lock_q[unit_idx];
  // aliased halves index one table entry, so one attribute governs both
  assign denied    = (state_q == SRG_ST_CHECK) && !dec_err && !lock_hit &&
                     has_unit && (unit_attr[unit_idx] != nonsec_q);
  assign access_ok = (state_q == SRG_ST_CHECK) && !dec_err && !lock_hit &&
                     !denied;
  assign excl_pass = (bank == SRG_BANK_EXPA) ? mon_pass[0] :
                     (bank == SRG_BANK_EXPB) ? mon_pass[1] : 1'b0;
  assign do_write  = write_q && !(excl_q && has_mon && !excl_pass);

  // ****************************************************************
  // exclusive access monitors on the two expansion banks
  // ****************************************************************
  genvar m;
  generate
    for (m = 0; m < SRG_NUM_MON; m++) begin : g_mon
      logic                        mon_valid_q;
      logic [SRG_MASTER_W-1:0]     mon_master_q;
      logic [SRG_UNIT_ADDR_W-1:2]  mon_addr_q;
      logic                        here;
      logic                        addr_hit;
      assign here        = (unit_idx == 2'(m + 1)) && has_mon;
      assign addr_hit    = mon_valid_q && (mon_addr_q == unit_off[SRG_UNIT_ADDR_W-1:2]);
      assign mon_pass[m] = addr_hit && (mon_master_q == master_q);
      always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
          mon_valid_q  <= 1'b0;
          mon_master_q <= '0;
          mon_addr_q   <= '0;
        end else if (access_ok && here) begin
          if (excl_q && !write_q) begin
            mon_valid_q  <= 1'b1;
            mon_master_q <= master_q;
            mon_addr_q   <= unit_off[SRG_UNIT_ADDR_W-1:2];
          end else if (do_write && addr_hit) begin
            mon_valid_q  <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // request capture
  // ****************************************************************
  assign take = (state_q == SRG_ST_IDLE) && HSEL_IN && HTRANS_IN[1] && HREADY_IN;
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      addr_q   <= '0;
      write_q  <= 1'b0;
      size_q   <= '0;
      nonsec_q <= 1'b0;
      excl_q   <= 1'b0;
      master_q <= '0;
    end else if (take) begin
      addr_q   <= HADDR_IN;
      write_q  <= HWRITE_IN;
      size_q   <= HSIZE_IN;
      nonsec_q <= HNONSEC_IN;
      excl_q   <= HEXCL_IN;
      master_q <= HMASTER_IN;
    end
  end

  // ****************************************************************
  // transfer state machine and ahb answer
  // ****************************************************************
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state_q       <= SRG_ST_IDLE;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT     <= 1'b0;
      HEXOKAY_OUT   <= 1'b0;
      HRDATA_OUT    <= SRG_RDATA_RST;
    end else begin
      case (state_q)
        SRG_ST_IDLE: begin
          HRESP_OUT <= 1'b0;
          if (take) begin
            HREADYOUT_OUT <= 1'b0;
            HEXOKAY_OUT   <= 1'b0;
            state_q       <= SRG_ST_CHECK;
          end else begin
            HREADYOUT_OUT <= 1'b1;
          end
        end
        SRG_ST_CHECK: begin
          if (dec_err || denied ||
              (lock_hit && locked_access_response_select)) begin
            HRESP_OUT <= 1'b1;
            state_q   <= SRG_ST_ERR;
          end else if (lock_hit) begin
            state_q <= SRG_ST_CHECK;
          end else if (write_q) begin
            HREADYOUT_OUT <= 1'b1;
            HEXOKAY_OUT   <= excl_q && excl_pass;
            state_q       <= SRG_ST_IDLE;
          end else begin
            HEXOKAY_OUT <= excl_q && has_mon;
            state_q     <= SRG_ST_READ;
          end
        end
        SRG_ST_READ: begin
          state_q <= SRG_ST_RDATA;
        end
        SRG_ST_RDATA: begin
          HRDATA_OUT    <= RAM_RDATA_IN[unit_idx*SRG_DATA_W +: SRG_DATA_W];
          HREADYOUT_OUT <= 1'b1;
          state_q       <= SRG_ST_IDLE;
        end
        SRG_ST_ERR: begin
          HREADYOUT_OUT <= 1'b1;
          state_q       <= SRG_ST_IDLE;
        end
        default: begin
          state_q <= SRG_ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // sram bank strobes; no strobe ever fires on an error path
  // ****************************************************************
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      RAM_SEL_OUT   <= '0;
      RAM_ADDR_OUT  <= '0;
      RAM_RD_OUT    <= 1'b0;
      RAM_WE_OUT    <= 1'b0;
      RAM_BE_OUT    <= '0;
      RAM_WDATA_OUT <= '0;
    end else begin
      RAM_RD_OUT <= access_ok && !write_q;
      RAM_WE_OUT <= access_ok && do_write;
      if (access_ok) begin
        RAM_SEL_OUT   <= 4'h1 << unit_idx;
        RAM_ADDR_OUT  <= ram_addr;
        RAM_BE_OUT    <= byte_en;
        RAM_WDATA_OUT <= HWDATA_IN;
      end else if (state_q == SRG_ST_IDLE) begin
        RAM_SEL_OUT <= '0;
      end
    end
  end
  // status outputs
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      SEC_EXP_PROT_IRQ_OUT <= '0;
      UNIT_LOCKED_OUT      <= '0;
    end else begin
      SEC_EXP_PROT_IRQ_OUT <= irq_q;
      UNIT_LOCKED_OUT      <= unit_lock_q;
    end
  end
endmodule

// >>> dv/srg_gate_props.sv
// Purpose: port checks for the sram decode and gating block
// Assumes: one clock domain, reset active low
// Notes:   bound to every srg_gate instance
`timescale 1ns/1ns

module srg_gate_props (
  input wire logic         CLOCK_IN,
  input wire logic         RESETN_IN,
  input wire logic         HSEL_IN,
  input wire logic [31:0]  HADDR_IN,
  input wire logic [1:0]   HTRANS_IN,
  input wire logic         HWRITE_IN,
  input wire logic         HREADY_IN,
  input wire logic         HNONSEC_IN,
  input wire logic [31:0]  HRDATA_OUT,
  input wire logic         HREADYOUT_OUT,
  input wire logic         HRESP_OUT,
  input wire logic [3:0]   RAM_SEL_OUT,
  input wire logic [23:0]  RAM_ADDR_OUT,
  input wire logic         RAM_RD_OUT,
  input wire logic         RAM_WE_OUT,
  input wire logic [127:0] RAM_RDATA_IN,
  input wire logic [2:0]   SEC_EXP_PROT_IRQ_OUT,
  input wire logic [2:0]   UNIT_LOCKED_OUT
);
  // ****************************************************************
  // helper terms and assertions
  // ****************************************************************
  logic take;
  logic code_win;
  logic code_hole;

  // accepted transfer and code window decode
  assign take = HSEL_IN & HTRANS_IN[1] & HREADY_IN & HREADYOUT_OUT;
  assign code_win = (HADDR_IN[31:29] == 3'h0) && (HADDR_IN[27:23] == 5'h00);
  assign code_hole = (HADDR_IN[31:29] == 3'h0) && (HADDR_IN[27:23] != 5'h00)
                     && (HADDR_IN[27:25] != 3'h7);

  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESETN_IN);

  a_err_two_cycle: assert property (
    $rose(HRESP_OUT) |-> !HREADYOUT_OUT ##1 (HRESP_OUT && HREADYOUT_OUT) ##1 !HRESP_OUT)
    else $error("error response shape wrong");
  a_err_no_strobe: assert property (
    HRESP_OUT |-> !RAM_WE_OUT && !RAM_RD_OUT) else $error("ram strobe during error");
  a_code_hole_err: assert property (
    take && code_hole |-> ##2 HRESP_OUT && !HREADYOUT_OUT) else $error("code hole no error");
  a_exp_tail_err: assert property (
    take && HADDR_IN[31:27] == 5'h05 && HADDR_IN[26:22] != 5'h00 |-> ##2 HRESP_OUT)
    else $error("expansion tail no error");
  a_large_tail_err: assert property (
    take && HADDR_IN[31:28] == 4'h8 && HADDR_IN[27:24] != 4'h0 |-> ##2 HRESP_OUT)
    else $error("large ram tail no error");
  a_large_write_map: assert property (
    take && HWRITE_IN && HNONSEC_IN && HADDR_IN[31:24] == 8'h80 |-> ##2 RAM_WE_OUT
    && RAM_SEL_OUT == 4'h8 && RAM_ADDR_OUT == $past(HADDR_IN[23:0], 2))
    else $error("large ram write misplaced");
  a_large_rdata: assert property (
    RAM_RD_OUT && RAM_SEL_OUT[3] |-> ##2 HREADYOUT_OUT
    && HRDATA_OUT == $past(RAM_RDATA_IN[127:96])) else $error("large ram read data wrong");
  a_code_alias_map: assert property (
    take && code_win && HWRITE_IN && !UNIT_LOCKED_OUT[0] |-> ##2 HRESP_OUT
    || (RAM_WE_OUT && RAM_SEL_OUT == 4'h1 && RAM_ADDR_OUT == {2'h0, $past(HADDR_IN[21:0], 2)}))
    else $error("code write misplaced");
  a_lock_stall: assert property (
    take && code_win && UNIT_LOCKED_OUT[0] |-> ##1
    (!HREADYOUT_OUT && !RAM_WE_OUT && !RAM_RD_OUT)[*4]) else $error("locked access not held");
  a_irq_on_deny: assert property (
    |(SEC_EXP_PROT_IRQ_OUT & ~$past(SEC_EXP_PROT_IRQ_OUT)) |-> HRESP_OUT
    || $past(HRESP_OUT) || $past(HRESP_OUT, 2)) else $error("irq without denied access");
  a_strobe_onehot: assert property (
    RAM_WE_OUT || RAM_RD_OUT |-> $onehot(RAM_SEL_OUT)) else $error("bank select not one-hot");

  c_lock: cover property (take && code_win && UNIT_LOCKED_OUT[0]);
  c_err: cover property ($rose(HRESP_OUT));
  c_large_rd: cover property (RAM_RD_OUT && RAM_SEL_OUT[3]);
endmodule

bind srg_gate srg_gate_props u_props (.CLOCK_IN, .RESETN_IN, .HSEL_IN, .HADDR_IN, .HTRANS_IN,
  .HWRITE_IN, .HREADY_IN, .HNONSEC_IN, .HRDATA_OUT, .HREADYOUT_OUT, .HRESP_OUT, .RAM_SEL_OUT,
  .RAM_ADDR_OUT, .RAM_RD_OUT, .RAM_WE_OUT, .RAM_RDATA_IN, .SEC_EXP_PROT_IRQ_OUT,
  .UNIT_LOCKED_OUT);

// >>> dv/srg_ram_model.sv
// Purpose: behavioural model of the four sram banks behind the gate
// Assumes: read data returned the cycle after a read strobe
// Notes:   lanes not being read show the inverse of their last value
`timescale 1ns/1ns

module srg_ram_model (
  input  wire logic         clk_in,
  input  wire logic [3:0]   sel_in,
  input  wire logic [23:0]  addr_in,
  input  wire logic         rd_in,
  input  wire logic         we_in,
  input  wire logic [3:0]   be_in,
  input  wire logic [31:0]  wdata_in,
  output logic      [127:0] rdata_out
);
  // ****************************************************************
  // storage and read port
  // ****************************************************************
  logic [31:0] mem [int];

  initial rdata_out = 128'h0;

  // byte-lane writes, read answer one cycle after the strobe
  always @(posedge clk_in) begin
    int k;
    rdata_out <= ~rdata_out;
    for (int b = 0; b < 4; b++) begin
      k = {b[1:0], addr_in[23:2]};
      if (sel_in[b] && rd_in)
        rdata_out[32*b +: 32] <= mem.exists(k) ? mem[k] : 32'h0;
      for (int j = 0; j < 4; j++)
        if (sel_in[b] && we_in && be_in[j])
          mem[k][8*j +: 8] = wdata_in[8*j +: 8];
    end
  end
endmodule

// >>> dv/srg_gate_tb_top.sv
// Purpose: self-checking bench for the sram decode and gating block
// Assumes: word transfers except one byte write, master ids 3 and 4, config by strobe
// Notes:   sram banks come from the behavioural model
`timescale 1ns/1ns

module srg_gate_tb_top
  import srg_pkg::*;
;
  // ****************************************************************
  // signals, clock, tasks and scenarios
  // ****************************************************************
  logic         clk, resetn, hsel, hwrite, hready, hnonsec, hexcl, cfg_we;
  logic         hreadyout, hresp, hexokay, ram_rd, ram_we;
  logic [1:0]   htrans;
  logic [2:0]   hsize, irq, locked;
  logic [4:0]   hmaster;
  logic [3:0]   ram_sel, ram_be;
  logic [23:0]  ram_addr;
  logic [31:0]  haddr, hwdata, hrdata, cfg_addr, cfg_wdata, ram_wdata;
  logic [127:0] ram_rdata;
  int           n_mismatch = 0;
  int           tests_run = 0;

  srg_gate DUT (.CLOCK_IN(clk), .RESETN_IN(resetn), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HREADY_IN(hready),
    .HWDATA_IN(hwdata), .HNONSEC_IN(hnonsec), .HEXCL_IN(hexcl), .HMASTER_IN(hmaster),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hreadyout), .HRESP_OUT(hresp),
    .HEXOKAY_OUT(hexokay), .CFG_WRITE_IN(cfg_we), .CFG_ADDR_IN(cfg_addr),
    .CFG_WDATA_IN(cfg_wdata), .RAM_SEL_OUT(ram_sel), .RAM_ADDR_OUT(ram_addr),
    .RAM_RD_OUT(ram_rd), .RAM_WE_OUT(ram_we), .RAM_BE_OUT(ram_be), .RAM_WDATA_OUT(ram_wdata),
    .RAM_RDATA_IN(ram_rdata), .SEC_EXP_PROT_IRQ_OUT(irq), .UNIT_LOCKED_OUT(locked));

  srg_ram_model u_ram (.clk_in(clk), .sel_in(ram_sel), .addr_in(ram_addr), .rd_in(ram_rd),
    .we_in(ram_we), .be_in(ram_be), .wdata_in(ram_wdata), .rdata_out(ram_rdata));

  // free-running 100 MHz clock
  always #5 clk = ~clk;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one transfer of size hsize; address released after the take edge
  task automatic xfer(input logic [31:0] a, input logic w, input logic ns, input logic ex,
      input logic [31:0] wd, output logic [31:0] rd, output logic er, output logic eo);
    int k;
    hsel = 1'b1;
    htrans = 2'h2;
    haddr = a;
    hwrite = w;
    hnonsec = ns;
    hexcl = ex;
    @(posedge clk);
    #1;
    htrans = 2'h0;
    haddr = ~a;
    hwdata = wd;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      #1;
      if (hreadyout === 1'b1) break;
    end
    if (k == 40) begin
      chk("timeout", 32'h0, 32'h1);
      stop_test();
    end
    rd = hrdata;
    er = hresp;
    eo = hexokay;
    hwdata = ~wd;
  endtask

  task automatic acc(input logic [31:0] a, input logic w, input logic ns,
      input logic [31:0] d, input logic e);
    logic [31:0] r;
    logic er, eo;
    xfer(a, w, ns, 1'b0, d, r, er, eo);
    chk("resp", {31'h0, e}, {31'h0, er});
    if (!w && !e) chk("rdata", d, r);
  endtask

  task automatic cfg(input int u, input logic [11:0] off, input logic [31:0] d);
    cfg_we = 1'b1;
    cfg_addr = SRG_CFG_BASE[u] + {20'h0, off};
    cfg_wdata = d;
    @(posedge clk);
    #1;
    cfg_we = 1'b0;
    cfg_addr = ~cfg_addr;
    cfg_wdata = ~d;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic chk_irq(input logic [2:0] exp);
    @(posedge clk);
    #1;
    chk("irq", {29'h0, exp}, {29'h0, irq});
  endtask

  task automatic t_reset();
    chk("ready", 32'h1, {31'h0, hreadyout});
    chk("resp", 32'h0, {31'h0, hresp});
    chk("locked", 32'h0, {29'h0, locked});
    chk_irq(3'h0);
    $display("test reset done");
  endtask

  task automatic t_code();
    acc(32'h1000_0010, 1'b1, 1'b0, 32'hA5A5_0001, 1'b0);
    acc(32'h1040_0010, 1'b0, 1'b0, 32'hA5A5_0001, 1'b0);
    acc(32'h0000_0010, 1'b0, 1'b1, 32'h0, 1'b1);
    chk_irq(3'h1);
    cfg(0, 12'h000, 32'h1);
    acc(32'h0040_0010, 1'b0, 1'b1, 32'hA5A5_0001, 1'b0);
    acc(32'h1000_0010, 1'b0, 1'b0, 32'h0, 1'b1);
    acc(32'h0000_0100, 1'b0, 1'b1, 32'h0, 1'b1);
    cfg(0, SRG_CFG_IRQ_CLR_OFF, 32'h1);
    chk_irq(3'h0);
    $display("test code done");
  endtask

  task automatic t_unmapped();
    logic [31:0] hole [7] = '{32'h0080_0000, 32'h0DFF_FFFC, 32'h1080_0000, 32'h2840_0000,
                              32'h2FFF_FFFC, 32'h8100_0000, 32'h9000_0000};
    foreach (hole[i]) acc(hole[i], 1'b0, 1'b1, 32'h0, 1'b1);
    acc(32'h0080_0010, 1'b1, 1'b1, 32'hDEAD_0000, 1'b1);
    acc(32'h0000_0010, 1'b0, 1'b1, 32'hA5A5_0001, 1'b0);
    $display("test unmapped done");
  endtask

  task automatic t_exp();
    logic [31:0] r;
    logic er, eo;
    acc(32'h3800_0100, 1'b1, 1'b0, 32'h1111_2222, 1'b0);
    acc(32'h3820_0100, 1'b1, 1'b0, 32'h3333_4444, 1'b0);
    acc(32'h3800_0100, 1'b0, 1'b0, 32'h1111_2222, 1'b0);
    acc(32'h2800_0100, 1'b0, 1'b1, 32'h0, 1'b1);
    acc(32'h2820_0100, 1'b0, 1'b1, 32'h0, 1'b1);
    chk_irq(3'h6);
    cfg(1, SRG_CFG_IRQ_CLR_OFF, 32'h1);
    cfg(2, SRG_CFG_IRQ_CLR_OFF, 32'h1);
    chk_irq(3'h0);
    cfg(1, 12'h000, 32'h2);
    acc(32'h2800_0100, 1'b0, 1'b1, 32'h1111_2222, 1'b0);
    xfer(32'h2800_0100, 1'b0, 1'b1, 1'b1, 32'h0, r, er, eo);
    chk("exokay", 32'h1, {31'h0, eo});
    hmaster = 5'h04;
    xfer(32'h2800_0100, 1'b1, 1'b1, 1'b1, 32'h7777_8888, r, er, eo);
    chk("exokay", 32'h0, {31'h0, eo});
    hmaster = 5'h03;
    acc(32'h2800_0100, 1'b1, 1'b1, 32'h5555_6666, 1'b0);
    xfer(32'h2800_0100, 1'b1, 1'b1, 1'b1, 32'h7777_8888, r, er, eo);
    chk("exokay", 32'h0, {31'h0, eo});
    acc(32'h2800_0100, 1'b0, 1'b1, 32'h5555_6666, 1'b0);
    $display("test expansion done");
  endtask

  task automatic t_large();
    acc(32'h80FF_FFFC, 1'b1, 1'b1, 32'h5A5A_7777, 1'b0);
    hsize = 3'h0;
    acc(32'h80FF_FFFD, 1'b1, 1'b1, 32'h0000_C300, 1'b0);
    hsize = 3'h2;
    acc(32'h80FF_FFFC, 1'b0, 1'b1, 32'h5A5A_C377, 1'b0);
    $display("test large done");
  endtask

  task automatic t_lock();
    cfg(0, SRG_CFG_LOCK_OFF, 32'h1);
    chk("locked", 32'h1, {29'h0, locked});
    fork
      acc(32'h0000_0010, 1'b0, 1'b1, 32'hA5A5_0001, 1'b0);
      begin
        repeat (8) @(posedge clk);
        #1;
        chk("stall", 32'h0, {31'h0, hreadyout});
        cfg(0, SRG_CFG_LOCK_OFF, 32'h0);
      end
    join
    chk("locked", 32'h0, {29'h0, locked});
    $display("test lock done");
  endtask

  // reset, scenarios, verdict
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    {hsel, hwrite, hnonsec, hexcl, cfg_we} = 5'h00;
    hready = 1'b1;
    htrans = 2'h0;
    hsize = 3'h2;
    hmaster = 5'h03;
    haddr = 32'h0;
    hwdata = 32'h0;
    cfg_addr = 32'h0;
    cfg_wdata = 32'h0;
    repeat (20) @(posedge clk);
    #1;
    resetn = 1'b1;
    t_reset();
    t_code();
    t_unmapped();
    t_exp();
    t_large();
    t_lock();
    stop_test();
  end
endmodule
